// File: pkg/csg_pkg.sv
package csg_pkg;
	localparam logic [11:0] CTRL_OFS = 12'h803;
	localparam logic [11:0] STAT_OFS = 12'h804;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [3:0] FLAG_RST = 4'h0;
	localparam int RING_BIT = 7;
	localparam int RESET_BIT = 6;
	localparam int KIND_BIT = 5;
	localparam int ROUTE_BIT = 4;
	localparam int DET_BIT = 3;
	localparam int RDY_BIT = 2;
	localparam int LOW_BIT = 1;
	localparam int DEAD_BIT = 0;
	localparam int FLAG_W = 4;
	localparam int IRQ_W = 16;
	localparam int PIN_W = 9;
	localparam logic [3:0] SEL_NONE = 4'h0;
	localparam logic [3:0] SEL_SMI = 4'h2;

	function automatic logic [IRQ_W-1:0] csg_decode(input logic [3:0] code);
		logic [IRQ_W-1:0] hot;
		hot = 16'h0000;
		unique case (code)
			4'h1, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'hf: hot = 16'h0001 << code;
			default: hot = 16'h0000;
		endcase
		return hot;
	endfunction
endpackage

// File: pkg/csg_link_if.sv
interface csg_link_if;
	logic [1:0] detect;
	logic ready;
	logic batteryCall;
	logic batteryTwo;
	logic statusPin;
	logic funcReq;
	logic busRst;
	logic globalRst;
	logic [7:0] ctrl;
	logic [3:0] statusSelect;
	logic diagRoute;
	logic statusPending;
	logic funcPending;
	logic pciIrq;
	logic [15:0] isaIrq;
	logic smiIrq;
	modport sync (output detect, ready, batteryCall, batteryTwo, statusPin, funcReq, busRst,
		globalRst);
	modport core (input detect, ready, batteryCall, batteryTwo, statusPin, funcReq, busRst,
		globalRst, pciIrq, isaIrq, smiIrq, output ctrl, statusSelect, diagRoute,
		statusPending, funcPending);
	modport route (input ctrl, statusSelect, diagRoute, statusPending, funcPending,
		output pciIrq, isaIrq, smiIrq);
endinterface

// File: rtl/csg_pin_sync.sv
module csg_pin_sync (
	input wire logic clk,
	input wire logic srst,
	input wire logic [csg_pkg::PIN_W-1:0] pins,
	csg_link_if.sync link
);
	typedef struct packed {
		logic [csg_pkg::PIN_W-1:0] first;
		logic [csg_pkg::PIN_W-1:0] second;
	} csg_sync_t;

	csg_sync_t st;
	csg_sync_t next_st;

	always_comb
	begin
		next_st.first = pins;
		next_st.second = st.first;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			st <= '0;
		else
			st <= next_st;
	end

	assign {link.globalRst, link.busRst, link.funcReq, link.statusPin, link.batteryTwo,
		link.batteryCall, link.ready, link.detect} = st.second;
endmodule

// File: rtl/csg_irq_route.sv
module csg_irq_route (
	csg_link_if.route link
);
	logic toPci;
	logic [csg_pkg::IRQ_W-1:0] statusHot;
	logic [csg_pkg::IRQ_W-1:0] funcHot;
	logic [3:0] funcSel;

	always_comb
	begin
		funcSel = link.ctrl[3:0];
		if (link.diagRoute)
			toPci = (link.statusSelect == csg_pkg::SEL_NONE);
		else
			toPci = link.ctrl[csg_pkg::ROUTE_BIT] | (funcSel == csg_pkg::SEL_NONE);
		statusHot = (link.statusPending && !toPci) ?
			csg_pkg::csg_decode(link.statusSelect) : '0;
		funcHot = link.funcPending ? csg_pkg::csg_decode(funcSel) : '0;
		link.pciIrq = link.statusPending && toPci;
		link.isaIrq = statusHot | funcHot;
		link.smiIrq = (link.statusPending && !toPci && link.statusSelect == csg_pkg::SEL_SMI)
			|| (link.funcPending && funcSel == csg_pkg::SEL_SMI);
	end
endmodule

// File: rtl/csg_top.sv
module csg_top (
	input wire logic clk,
	input wire logic srst,
	input wire logic busResetPin,
	input wire logic globalResetPin,
	input wire logic powerWakeEnable,
	input wire logic diagRouteSelect,
	input wire logic clearOnWrite,
	input wire logic [3:0] statusChangeSelect,
	input wire logic [3:0] irqEnables,
	input wire logic detectPinOneN,
	input wire logic detectPinTwoN,
	input wire logic cardReady,
	input wire logic batteryCallPin,
	input wire logic batteryTwoPin,
	input wire logic cardStatusChangePin,
	input wire logic cardFuncIrqN,
	input wire logic [11:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	output logic regRdValid,
	output logic cardReset,
	output logic ringIndicateMode,
	output logic cardIsIo,
	output logic statusChangeEvent,
	output logic pciIrq,
	output logic [15:0] isaIrq,
	output logic smiIrq
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [3:0] flags;
		logic [1:0] detectPrev;
		logic readyPrev;
		logic lowPrev;
		logic deadPrev;
		logic [7:0] rdData;
		logic rdValid;
		logic [2:0] warm;
	} csg_state_t;

	csg_state_t st;
	csg_state_t next_st;
	csg_link_if link();

	logic ctrlWr;
	logic statWr;
	logic statRd;
	logic isIo;
	logic ringOn;
	logic batLow;
	logic battery_dead_flag;
	logic allClr;
	logic ctxClr;
	logic [3:0] setVec;
	logic [3:0] clrVec;
	logic [3:0] view;
	logic [7:0] ctxMask;

	csg_pin_sync u_sync (
		.clk(clk),
		.srst(srst),
		.pins({globalResetPin, busResetPin, cardFuncIrqN, cardStatusChangePin, batteryTwoPin,
			batteryCallPin, cardReady, detectPinTwoN, detectPinOneN}),
		.link(link.sync)
	);

	csg_irq_route u_route (
		.link(link.route)
	);

	always_comb
	begin
		ctrlWr = regWrEn && regAddr == csg_pkg::CTRL_OFS;
		statWr = regWrEn && regAddr == csg_pkg::STAT_OFS;
		statRd = regRdEn && regAddr == csg_pkg::STAT_OFS;
		isIo = st.ctrl[csg_pkg::KIND_BIT];
		ringOn = st.ctrl[csg_pkg::RING_BIT];
		battery_dead_flag = !link.batteryTwo;
		batLow = link.batteryTwo && !link.batteryCall;
		allClr = link.globalRst || link.busRst;
		ctxClr = link.globalRst || (link.busRst && !powerWakeEnable);
		ctxMask = 8'h00;
		ctxMask[csg_pkg::RESET_BIT] = 1'b1;
		ctxMask[csg_pkg::KIND_BIT] = 1'b1;
		setVec[csg_pkg::DET_BIT] = link.detect != st.detectPrev;
		setVec[csg_pkg::RDY_BIT] = !isIo && link.ready && !st.readyPrev;
		setVec[csg_pkg::LOW_BIT] = !isIo && batLow && !st.lowPrev;
		setVec[csg_pkg::DEAD_BIT] = !isIo && !ringOn && battery_dead_flag && !st.deadPrev;
		// Pin history is not trusted until the sync chain has refilled after reset
		setVec = setVec & irqEnables & {csg_pkg::FLAG_W{st.warm[2]}};
		clrVec = 4'h0;
		if (statRd && !clearOnWrite)
			clrVec = 4'hf;
		if (statWr && clearOnWrite)
			clrVec = regWrData[3:0];
		view = st.flags;
		if (ringOn)
			view[csg_pkg::DEAD_BIT] = link.batteryCall;
		else if (isIo)
			view[csg_pkg::DEAD_BIT] = link.statusPin;
		view = view & irqEnables;

		next_st = st;
		next_st.warm = {st.warm[1:0], 1'b1};
		next_st.detectPrev = link.detect;
		next_st.readyPrev = link.ready;
		next_st.lowPrev = batLow;
		next_st.deadPrev = battery_dead_flag;
		next_st.flags = ((st.flags & ~clrVec) | setVec) & irqEnables;
		if (isIo)
		begin
			next_st.flags[csg_pkg::RDY_BIT] = 1'b0;
			next_st.flags[csg_pkg::LOW_BIT] = 1'b0;
		end
		if (isIo || ringOn)
			next_st.flags[csg_pkg::DEAD_BIT] = 1'b0;
		if (ctrlWr)
			next_st.ctrl = regWrData;
		if (allClr)
			next_st.ctrl = (next_st.ctrl & ctxMask) | (csg_pkg::CTRL_RST & ~ctxMask);
		if (ctxClr)
		begin
			next_st.ctrl = (next_st.ctrl & ~ctxMask) | (csg_pkg::CTRL_RST & ctxMask);
			next_st.flags = csg_pkg::FLAG_RST;
		end
		next_st.rdValid = regRdEn;
		next_st.rdData = 8'h00;
		if (regRdEn && regAddr == csg_pkg::CTRL_OFS)
			next_st.rdData = st.ctrl;
		else if (statRd)
			next_st.rdData = {4'h0, view};
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st <= '0;
			st.ctrl <= csg_pkg::CTRL_RST;
			st.flags <= csg_pkg::FLAG_RST;
		end
		else
			st <= next_st;
	end

	assign link.ctrl = st.ctrl;
	assign link.statusSelect = statusChangeSelect;
	assign link.diagRoute = diagRouteSelect;
	assign link.statusPending = |view;
	assign link.funcPending = isIo && !link.funcReq;
	assign regRdData = st.rdData;
	assign regRdValid = st.rdValid;
	assign cardReset = !st.ctrl[csg_pkg::RESET_BIT];
	assign ringIndicateMode = ringOn;
	assign cardIsIo = isIo;
	assign statusChangeEvent = |view;
	assign pciIrq = link.pciIrq;
	assign isaIrq = link.isaIrq;
	assign smiIrq = link.smiIrq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	property p_ring_write;
		ctrlWr && !allClr |=> ringIndicateMode == $past(regWrData[7]);
	endproperty
	a_ring_write: assert property (p_ring_write) else $error("ring mode not written");

	property p_reset_release;
		ctrlWr && regWrData[6] && !allClr
			|=> !cardReset ##1 (!cardReset || $past(ctrlWr) || $past(ctxClr));
	endproperty
	a_reset_release: assert property (p_reset_release) else $error("card reset wrong");

	property p_kind_io_masks;
		cardIsIo |-> !regRdValid || !$past(statRd) || regRdData[2:1] == 2'b00;
	endproperty
	a_kind_io_masks: assert property (p_kind_io_masks) else $error("io card flag set");

	property p_disabled_zero;
		statRd && !irqEnables[3] |=> regRdData[3] == 1'b0;
	endproperty
	a_disabled_zero: assert property (p_disabled_zero) else $error("disabled flag read");

	property p_reserved_zero;
		statRd |=> regRdValid && regRdData[7:4] == 4'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_detect_set;
		link.detect != st.detectPrev && irqEnables[3] && st.warm[2] && !ctxClr |=> st.flags[3];
	endproperty
	a_detect_set: assert property (p_detect_set) else $error("detect change lost");

	property p_read_clear;
		statRd && !clearOnWrite && setVec == 4'h0 |=> st.flags == 4'h0;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear");

	property p_wake_hold;
		link.busRst && !link.globalRst && powerWakeEnable && !ctrlWr
			|=> st.ctrl[6:5] == $past(st.ctrl[6:5]);
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("context bits lost");

	property p_ctx_clear;
		ctxClr |=> st.flags == 4'h0 && cardReset && !cardIsIo;
	endproperty
	a_ctx_clear: assert property (p_ctx_clear) else $error("context not cleared");

	property p_irq_needs_flag;
		(pciIrq || (|link.isaIrq && !link.funcPending)) |-> statusChangeEvent;
	endproperty
	a_irq_needs_flag: assert property (p_irq_needs_flag) else $error("irq without flag");

	property p_read_valid;
		regRdEn |=> regRdValid;
	endproperty
	a_read_valid: assert property (p_read_valid) else $error("read not answered");

	property p_read_idle;
		!regRdEn |=> !regRdValid && regRdData == 8'h00;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data lingers");

	property p_ctrl_read;
		regRdEn && regAddr == csg_pkg::CTRL_OFS |=> regRdData == $past(st.ctrl);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

	property p_kind_write;
		ctrlWr && !allClr |=> cardIsIo == $past(regWrData[csg_pkg::KIND_BIT]);
	endproperty
	a_kind_write: assert property (p_kind_write) else $error("card kind not written");

	property p_route_pci;
		!diagRouteSelect && statusChangeEvent
			&& (st.ctrl[csg_pkg::ROUTE_BIT] || st.ctrl[3:0] == csg_pkg::SEL_NONE) |-> pciIrq;
	endproperty
	a_route_pci: assert property (p_route_pci) else $error("status not on pci");

	property p_diag_route;
		diagRouteSelect && statusChangeSelect != csg_pkg::SEL_NONE |-> !pciIrq;
	endproperty
	a_diag_route: assert property (p_diag_route) else $error("diag route ignored");

	property p_smi_only;
		smiIrq |-> (statusChangeEvent && statusChangeSelect == csg_pkg::SEL_SMI)
			|| (link.funcPending && st.ctrl[3:0] == csg_pkg::SEL_SMI);
	endproperty
	a_smi_only: assert property (p_smi_only) else $error("smi without source");

	property p_func_route;
		link.funcPending && st.ctrl[3:0] == 4'h7 |-> isaIrq[7];
	endproperty
	a_func_route: assert property (p_func_route) else $error("function irq lost");

	property p_io_flags_zero;
		cardIsIo && $past(cardIsIo)
			|-> !st.flags[csg_pkg::RDY_BIT] && !st.flags[csg_pkg::LOW_BIT];
	endproperty
	a_io_flags_zero: assert property (p_io_flags_zero) else $error("io card memory flag");

	property p_ring_flag;
		statRd && ringIndicateMode && irqEnables[csg_pkg::DEAD_BIT]
			|=> regRdData[csg_pkg::DEAD_BIT] == $past(link.batteryCall);
	endproperty
	a_ring_flag: assert property (p_ring_flag) else $error("ring state not shown");

	property p_status_level;
		statRd && cardIsIo && !ringIndicateMode && irqEnables[csg_pkg::DEAD_BIT]
			|=> regRdData[csg_pkg::DEAD_BIT] == $past(link.statusPin);
	endproperty
	a_status_level: assert property (p_status_level) else $error("status pin not shown");

	property p_bus_clear;
		allClr |=> !ringIndicateMode && !st.ctrl[csg_pkg::ROUTE_BIT]
			&& st.ctrl[3:0] == csg_pkg::SEL_NONE;
	endproperty
	a_bus_clear: assert property (p_bus_clear) else $error("bus reset missed");

	property p_flag_event;
		|(st.flags[3:1] & irqEnables[3:1]) |-> statusChangeEvent;
	endproperty
	a_flag_event: assert property (p_flag_event) else $error("flag without event");

	property p_write_clear;
		statWr && clearOnWrite && setVec == 4'h0 |=> (st.flags & $past(regWrData[3:0])) == 4'h0;
	endproperty
	a_write_clear: assert property (p_write_clear) else $error("write did not clear");

	c_detect_irq: cover property (st.flags[3] && pciIrq);
	c_write_clear: cover property (statWr && clearOnWrite && |st.flags ##1 st.flags == 4'h0);
	c_ring_view: cover property (ringIndicateMode && statusChangeEvent);
	c_smi_route: cover property (smiIrq);
	c_func_irq: cover property (link.funcPending && |isaIrq);
endmodule

// File: verification/csg_card_model.sv
module csg_card_model (
	input wire logic clk,
	input wire logic cardReset,
	input wire logic present,
	input wire logic [1:0] batt,
	input wire logic stat,
	input wire logic fIrq,
	output logic [1:0] detectN,
	output logic ready,
	output logic [1:0] battery,
	output logic statusOut,
	output logic irqN
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] boot = 3'h0;
	// Ready comes up only some cycles after reset is let go
	always @(posedge clk)
	begin
		if (cardReset)
			boot <= 3'h0;
		else if (boot != 3'h7)
			boot <= boot + 3'h1;
	end
	assign ready = (boot == 3'h7);
	assign detectN = present ? 2'b00 : 2'b11;
	assign battery = batt;
	assign statusOut = stat;
	assign irqN = ~fIrq;
endmodule

// File: verification/test_card_socket_irq_general_control.sv
module test_card_socket_irq_general_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, srst = 1'b1, bRst = 1'b0, global_reset_pin = 1'b0, wake = 1'b0, diag = 1'b0;
	logic cow = 1'b0, pres = 1'b0, stat = 1'b0, fIrq = 1'b0, wrEn = 1'b0, rdEn = 1'b0;
	logic [3:0] sel = 4'h0, en = 4'h0;
	logic [1:0] batt = 2'h3, detN, bat;
	logic [11:0] addr = 12'h000;
	logic [7:0] wdat = 8'h00, rdat, got;
	logic rdv, cRst, ring, isIo, evt, pci, system_mgmt_irq, rdy, sts, irqN;
	logic [15:0] isa;
	logic [3:0] codes [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'hf};
	int n_fail = 0, check_count = 0;
	always #20 clk = ~clk;
	csg_card_model u_card (.clk(clk), .cardReset(cRst), .present(pres), .batt(batt),
		.stat(stat), .fIrq(fIrq), .detectN(detN), .ready(rdy), .battery(bat),
		.statusOut(sts), .irqN(irqN));
	csg_top u_dut (.clk(clk), .srst(srst), .busResetPin(bRst), .globalResetPin(global_reset_pin),
		.powerWakeEnable(wake), .diagRouteSelect(diag), .clearOnWrite(cow),
		.statusChangeSelect(sel), .irqEnables(en), .detectPinOneN(detN[0]),
		.detectPinTwoN(detN[1]), .cardReady(rdy), .batteryCallPin(bat[0]),
		.batteryTwoPin(bat[1]), .cardStatusChangePin(sts), .cardFuncIrqN(irqN),
		.regAddr(addr), .regWrEn(wrEn), .regRdEn(rdEn), .regWrData(wdat), .regRdData(rdat),
		.regRdValid(rdv), .cardReset(cRst), .ringIndicateMode(ring), .cardIsIo(isIo),
		.statusChangeEvent(evt), .pciIrq(pci), .isaIrq(isa), .smiIrq(system_mgmt_irq));
	task automatic end_of_test();
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [16:0] g, input logic [16:0] e);
		check_count++;
		if (g !== e)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
			n_fail++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		wrEn <= 1'b1;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		wrEn <= 1'b0;
		tick(1);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		rdEn <= 1'b1;
		addr <= a;
		@(posedge clk);
		rdEn <= 1'b0;
		#1;
		chk(rdv, 1'b1);
		chk(rdat, e);
	endtask
	task automatic flip(input logic [3:0] e);
		@(posedge clk);
		en <= e;
		pres <= ~pres;
		tick(6);
	endtask
	task automatic pulse(input logic g);
		@(posedge clk);
		if (g)
			global_reset_pin <= 1'b1;
		else
			bRst <= 1'b1;
		repeat (4) @(posedge clk);
		global_reset_pin <= 1'b0;
		bRst <= 1'b0;
		tick(6);
	endtask
	task automatic t_basic();
		rdc(12'h803, 8'h00);
		rdc(12'h7ff, 8'h00);
		chk(cRst, 1'b1);
		wr(12'h803, 8'he0);
		rdc(12'h803, 8'he0);
		chk({ring, cRst, isIo}, 3'b101);
		wr(12'h803, 8'h00);
	endtask
	task automatic t_flags();
		flip(4'h8);
		chk({evt, pci}, 2'b11);
		rdc(12'h804, 8'h08);
		rdc(12'h804, 8'h00);
		chk(evt, 1'b0);
		flip(4'h0);
		rdc(12'h804, 8'h00);
		@(posedge clk);
		cow <= 1'b1;
		flip(4'h8);
		rdc(12'h804, 8'h08);
		wr(12'h804, 8'h08);
		rdc(12'h804, 8'h00);
	endtask
	task automatic t_route();
		flip(4'h8);
		wr(12'h803, 8'h01);
		foreach (codes[i])
		begin
			@(posedge clk);
			sel <= codes[i];
			tick(1);
			chk({system_mgmt_irq, isa}, codes[i] == 4'h2 ? 17'h10000 : 17'h00001 << codes[i]);
		end
		chk(pci, 1'b0);
		wr(12'h803, 8'h11);
		chk({pci, isa}, 17'h10000);
		@(posedge clk);
		diag <= 1'b1;
		sel <= 4'h3;
		tick(1);
		chk({pci, isa}, 17'h00008);
		@(posedge clk);
		sel <= 4'h0;
		tick(1);
		chk(pci, 1'b1);
		@(posedge clk);
		diag <= 1'b0;
		wr(12'h804, 8'h08);
		wr(12'h803, 8'h00);
	endtask
	task automatic t_card();
		@(posedge clk);
		cow <= 1'b0;
		en <= 4'h7;
		wr(12'h803, 8'h40);
		tick(12);
		rdc(12'h804, 8'h04);
		@(posedge clk);
		batt <= 2'h2;
		tick(6);
		rdc(12'h804, 8'h02);
		@(posedge clk);
		batt <= 2'h0;
		tick(6);
		rdc(12'h804, 8'h01);
		@(posedge clk);
		batt <= 2'h3;
		wr(12'h803, 8'h00);
		wr(12'h803, 8'h60);
		tick(12);
		@(posedge clk);
		batt <= 2'h2;
		tick(6);
		rdc(12'h804, 8'h00);
		@(posedge clk);
		stat <= 1'b1;
		tick(6);
		rdc(12'h804, 8'h01);
		@(posedge clk);
		stat <= 1'b0;
		fIrq <= 1'b1;
		wr(12'h803, 8'h67);
		tick(6);
		chk(isa, 16'h0080);
		@(posedge clk);
		fIrq <= 1'b0;
		batt <= 2'h3;
		en <= 4'h1;
		wr(12'h803, 8'h80);
		tick(6);
		rdc(12'h804, 8'h01);
		@(posedge clk);
		batt <= 2'h2;
		tick(6);
		rdc(12'h804, 8'h00);
	endtask
	task automatic t_resets();
		@(posedge clk);
		wake <= 1'b1;
		cow <= 1'b1;
		wr(12'h803, 8'h61);
		flip(4'h8);
		pulse(1'b0);
		rdc(12'h803, 8'h60);
		rdc(12'h804, 8'h08);
		pulse(1'b1);
		rdc(12'h803, 8'h00);
		rdc(12'h804, 8'h00);
		@(posedge clk);
		wake <= 1'b0;
		wr(12'h803, 8'h61);
		flip(4'h8);
		pulse(1'b0);
		rdc(12'h803, 8'h00);
		rdc(12'h804, 8'h00);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		tick(4);
		t_basic();
		t_flags();
		t_route();
		t_card();
		t_resets();
		end_of_test();
	end
	initial
	begin
		#400000;
		n_fail++;
		end_of_test();
	end
endmodule
